// file: timer_regs.vh
// register map, field positions, reset values and dividers of the reload timer
// Contract
// - count is 16 bits: low and high byte
// - mode select: clock/12 or external count pin
// - count (both bytes) counts only while run bit set
// - capture, auto-reload, baud modes from three bits
// - up/down enable: direction pin sets count direction
// - up overflow past ffff sets flag, interrupt
// - up overflow loads reload pair into count, or 0000 in capture mode
// - down: count equals reload, flag, load ffff
// - up/down: external flag toggles, no interrupt
// - up/down clear: plain up-counting reload timer
// - clock-out: 50% duty, count at clock/2
// - clock-out: reload at overflow, no interrupt
// - clock-out frequency clk/(4*(65536-reload)) on pin
// - baud and clock-out together share reload pair
// - overflow flag only without serial clocking; software clears
// - falling direction pin edge: capture/reload, external flag; the code ignores the edge under serial clocking
// - serial clocking forces auto-reload, ignores capture select
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

`define ADDR_W          4
`define OFF_CONTROL     4'h0
`define OFF_MODE        4'h1
`define OFF_COUNT_LO    4'h2
`define OFF_COUNT_HI    4'h3
`define OFF_RELOAD_LO   4'h4
`define OFF_RELOAD_HI   4'h5
`define OFF_IRQ_STATUS  4'h6
`define OFF_IRQ_MASK    4'h7

// control register fields
`define B_OVERFLOW      7
`define B_EXTERNAL      6
`define B_RX_CLOCK      5
`define B_TX_CLOCK      4
`define B_EXT_ENABLE    3
`define B_RUN           2
`define B_COUNTER_MODE  1
`define B_CAPTURE       0
// mode register fields
`define B_CLOCK_OUT_EN  1
`define B_UPDOWN_EN     0
// interrupt status / mask fields
`define B_EV_OVERFLOW   0
`define B_EV_EXTERNAL   1
`define IRQ_W           2

`define CONTROL_RESET   8'h00
`define MODE_RESET      2'h0
`define COUNT_RESET     16'h0000
`define RELOAD_RESET    16'h0000
`define IRQ_RESET       2'h0
`define COUNT_MAX       16'hffff
`define COUNT_STEP      16'h0001
`define PIN_OUT_RESET   1'b1

// prescaler terminal counts: divide by 12 and by 2
`define PRE_W           4
`define PRE_TIMER       4'hb
`define PRE_FAST        4'h1

`endif

// file: pin_sync.v
// two-flop synchroniser with falling-edge detect for a pin input
`timescale 1ns/10ps
module pin_sync (
   input  wire sys_clk,
   input  wire nrst,
   input  wire pin,
   output wire level,
   output wire fall
);
   reg meta;
   reg stable;
   reg last;

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         meta   <= 1'b1;
         stable <= 1'b1;
         last   <= 1'b1;
      end else begin
         meta   <= pin;
         stable <= meta;
         last   <= stable;
      end
   end

   assign level = stable;
   // edge seen from the stable flop only, never from meta
   assign fall  = last & ~stable;
endmodule // pin_sync

// file: updown_reload_timer_clockout.v
// 16-bit up/down auto-reload timer with capture, baud tick and clock-out
`timescale 1ns/10ps
`include "timer_regs.vh"
module updown_reload_timer_clockout (
   input  wire              sys_clk,
   input  wire              nrst,
   input  wire [`ADDR_W-1:0] addr,
   input  wire [7:0]        wdata,
   input  wire              wr,
   input  wire              rd,
   output reg  [7:0]        rdata,
   input  wire              count_pin_in,
   output reg               count_pin_out,
   output reg               count_pin_oe,
   input  wire              direction_trigger_pin,
   output reg               baud_tick,
   output reg               irq
);

   reg  [7:0]           timer_control_reg;
   reg  [1:0]           timer_mode_reg;
   reg  [15:0]          count;
   reg  [15:0]          reload;
   reg  [`IRQ_W-1:0]    irq_status;
   reg  [`IRQ_W-1:0]    irq_mask;
   reg  [`PRE_W-1:0]    prescale;

   reg  [15:0]          next_count;
   reg  [15:0]          next_reload;
   reg  [7:0]           next_control;
   reg  [`IRQ_W-1:0]    next_status;
   reg  [`PRE_W-1:0]    next_prescale;
   reg                  next_pin_out;
   reg                  ev_overflow;
   reg                  ev_external;
   reg                  ext_toggle;
   reg                  pin_toggle;
   reg                  baud_pulse;
   reg                  tick;
   reg  [7:0]           read_mux;

   wire                 count_fall;
   wire                 dir_level;
   wire                 dir_fall;

   pin_sync count_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .pin     (count_pin_in),
      .level   (),
      .fall    (count_fall)
   );

   pin_sync dir_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .pin     (direction_trigger_pin),
      .level   (dir_level),
      .fall    (dir_fall)
   );

   wire rx_clock_select       = timer_control_reg[`B_RX_CLOCK];
   wire tx_clock_select       = timer_control_reg[`B_TX_CLOCK];
   wire external_enable       = timer_control_reg[`B_EXT_ENABLE];
   wire run_bit               = timer_control_reg[`B_RUN];
   wire counter_mode_select   = timer_control_reg[`B_COUNTER_MODE];
   wire capture_reload_select = timer_control_reg[`B_CAPTURE];
   wire clock_out_enable      = timer_mode_reg[`B_CLOCK_OUT_EN];
   wire updown_enable         = timer_mode_reg[`B_UPDOWN_EN];

   // mode decode
   wire serial_clk   = rx_clock_select | tx_clock_select;
   wire clock_out    = clock_out_enable & ~counter_mode_select;
   wire capture_mode = capture_reload_select & ~serial_clk & ~clock_out;
   wire updown_mode  = updown_enable & ~capture_mode & ~serial_clk
                       & ~clock_out;
   wire ext_counting = counter_mode_select & ~clock_out;
   wire [`PRE_W-1:0] pre_term = (serial_clk | clock_out) ? `PRE_FAST
                                                         : `PRE_TIMER;

   wire wr_control = wr & (addr == `OFF_CONTROL);
   wire wr_mode    = wr & (addr == `OFF_MODE);
   wire wr_cnt_lo  = wr & (addr == `OFF_COUNT_LO);
   wire wr_cnt_hi  = wr & (addr == `OFF_COUNT_HI);
   wire wr_rld_lo  = wr & (addr == `OFF_RELOAD_LO);
   wire wr_rld_hi  = wr & (addr == `OFF_RELOAD_HI);
   wire wr_status  = wr & (addr == `OFF_IRQ_STATUS);
   wire wr_mask    = wr & (addr == `OFF_IRQ_MASK);

   // count source select
   always @* begin
      next_prescale = prescale + {{(`PRE_W-1){1'b0}}, 1'b1};
      if (prescale >= pre_term)
         next_prescale = {`PRE_W{1'b0}};
      if (ext_counting)
         tick = count_fall;
      else
         tick = (prescale >= pre_term);
   end

   // counting, reload, capture and software writes
   always @* begin
      next_count   = count;
      next_reload  = reload;
      ev_overflow  = 1'b0;
      ev_external  = 1'b0;
      ext_toggle   = 1'b0;
      pin_toggle   = 1'b0;
      baud_pulse   = 1'b0;
      // no counting while stopped; trigger edges and writes below still act
      if (run_bit && tick) begin
         if (updown_mode && !dir_level) begin
            if (count == reload) begin
               next_count  = `COUNT_MAX;
               ev_overflow = 1'b1;
               ext_toggle  = 1'b1;
            end else begin
               next_count = count - `COUNT_STEP;
            end
         end else if (count == `COUNT_MAX) begin
            if (serial_clk)
               baud_pulse = 1'b1;
            if (clock_out)
               pin_toggle = 1'b1;
            if (!serial_clk && !clock_out)
               ev_overflow = 1'b1;
            if (updown_mode)
               ext_toggle = 1'b1;
            if (capture_mode)
               next_count = `COUNT_RESET;
            else
               next_count = reload;
         end else begin
            next_count = count + `COUNT_STEP;
         end
      end
      // trigger edge: direction pin doubles as trigger outside up/down and serial clocking
      if (dir_fall && external_enable && !serial_clk && !updown_mode) begin
         ev_external = 1'b1;
         if (capture_mode)
            next_reload = count;
         else
            next_count = reload;
      end
      // software writes win over the counter for the byte they touch
      if (wr_cnt_lo)
         next_count[7:0] = wdata;
      if (wr_cnt_hi)
         next_count[15:8] = wdata;
      if (wr_rld_lo)
         next_reload[7:0] = wdata;
      if (wr_rld_hi)
         next_reload[15:8] = wdata;
   end

   // control flags: hardware set beats a software clear
   always @* begin
      next_control = timer_control_reg;
      if (wr_control)
         next_control = wdata;
      if (ev_overflow)
         next_control[`B_OVERFLOW] = 1'b1;
      if (ev_external)
         next_control[`B_EXTERNAL] = 1'b1;
      if (ext_toggle)
         next_control[`B_EXTERNAL] = ~next_control[`B_EXTERNAL];
   end

   // sticky status; toggles of the 17th bit raise nothing
   always @* begin
      next_status = irq_status;
      if (wr_status)
         next_status = irq_status & ~wdata[`IRQ_W-1:0];
      if (ev_overflow)
         next_status[`B_EV_OVERFLOW] = 1'b1;
      if (ev_external)
         next_status[`B_EV_EXTERNAL] = 1'b1;
   end

   always @* begin
      next_pin_out = count_pin_out;
      if (!clock_out)
         next_pin_out = `PIN_OUT_RESET;
      else if (pin_toggle)
         next_pin_out = ~count_pin_out;
   end

   always @* begin
      case (addr)
         `OFF_CONTROL:    read_mux = timer_control_reg;
         `OFF_MODE:       read_mux = {6'h00, timer_mode_reg};
         `OFF_COUNT_LO:   read_mux = count[7:0];
         `OFF_COUNT_HI:   read_mux = count[15:8];
         `OFF_RELOAD_LO:  read_mux = reload[7:0];
         `OFF_RELOAD_HI:  read_mux = reload[15:8];
         `OFF_IRQ_STATUS: read_mux = {6'h00, irq_status};
         `OFF_IRQ_MASK:   read_mux = {6'h00, irq_mask};
         default:         read_mux = 8'h00;
      endcase
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         timer_control_reg <= `CONTROL_RESET;
         timer_mode_reg    <= `MODE_RESET;
         count             <= `COUNT_RESET;
         reload            <= `RELOAD_RESET;
         irq_status        <= `IRQ_RESET;
         irq_mask          <= `IRQ_RESET;
         prescale          <= {`PRE_W{1'b0}};
         rdata             <= 8'h00;
         count_pin_out     <= `PIN_OUT_RESET;
         count_pin_oe      <= 1'b0;
         baud_tick         <= 1'b0;
         irq               <= 1'b0;
      end else begin
         timer_control_reg <= next_control;
         if (wr_mode)
            timer_mode_reg <= wdata[1:0];
         if (wr_mask)
            irq_mask <= wdata[`IRQ_W-1:0];
         count         <= next_count;
         reload        <= next_reload;
         irq_status    <= next_status;
         prescale      <= next_prescale;
         rdata         <= rd ? read_mux : 8'h00;
         count_pin_out <= next_pin_out;
         count_pin_oe  <= clock_out;
         baud_tick     <= baud_pulse;
         irq           <= |(irq_status & irq_mask);
      end
   end

endmodule // updown_reload_timer_clockout

// file: timer_props.sv
// port-level checker for the reload timer
`timescale 1ns/10ps
`include "timer_regs.vh"
module timer_props (
   input wire               sys_clk,
   input wire               nrst,
   input wire [`ADDR_W-1:0] addr,
   input wire [7:0]         wdata,
   input wire               wr,
   input wire               rd,
   input wire [7:0]         rdata,
   input wire               count_pin_in,
   input wire               count_pin_out,
   input wire               count_pin_oe,
   input wire               direction_trigger_pin,
   input wire               baud_tick,
   input wire               irq
);
   reg  [7:0]  ctl;
   reg  [1:0]  mode;
   reg  [15:0] rl;
   reg  [1:0]  mask;
   reg  [17:0] hc;
   reg         po;
   reg         v;
   wire        tog   = count_pin_out ^ po;
   wire        co_on = mode[1] && ctl[2];
   wire [17:0] half  = 18'h20000 - {1'b0, rl, 1'b0};
   // shadows of software writes only; hardware flag sets and reload captures are not tracked
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctl  <= 8'h00;
         mode <= 2'h0;
         rl   <= 16'h0000;
         mask <= 2'h0;
         hc   <= 18'h00000;
         po   <= 1'b1;
         v    <= 1'b0;
      end else begin
         if (wr && addr == `OFF_CONTROL) ctl <= wdata;
         if (wr && addr == `OFF_MODE) mode <= wdata[1:0];
         if (wr && addr == `OFF_RELOAD_LO) rl[7:0] <= wdata;
         if (wr && addr == `OFF_RELOAD_HI) rl[15:8] <= wdata;
         if (wr && addr == `OFF_IRQ_MASK) mask <= wdata[1:0];
         po <= count_pin_out;
         hc <= tog ? 18'h00000 : hc + 18'h00001;
         // any write may shift the period, so measurement restarts
         v  <= (wr || !co_on) ? 1'b0 : (tog ? 1'b1 : v);
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence co_steady;
      co_on ##1 co_on;
   endsequence
   sequence co_off;
      !mode[1] ##1 !mode[1] ##1 !mode[1];
   endsequence
   oe_on_a: assert property (co_steady |-> count_pin_oe)
      else $error("count pin not driven in clock-out");
   pin_idle_a: assert property (co_off |-> count_pin_out && !count_pin_oe)
      else $error("count pin active outside clock-out");
   run_frozen_a: assert property (!ctl[2] && $past(!ctl[2]) && $past(!ctl[2], 2)
      && mode == $past(mode) && mode == $past(mode, 2) |-> $stable(count_pin_out) && !baud_tick)
      else $error("activity while stopped");
   baud_src_a: assert property (baud_tick |-> $past(ctl[5] | ctl[4]) ||
      $past(ctl[5] | ctl[4], 2)) else $error("baud tick without serial select");
   baud_pulse_a: assert property (baud_tick |=> !baud_tick)
      else $error("baud tick longer than one cycle");
   irq_mask_a: assert property (irq |-> $past(mask) != 2'h0)
      else $error("irq with all sources masked");
   rd_quiet_a: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside read cycle");
   half_exact_a: assert property (tog && v |-> hc == half - 18'h00001)
      else $error("clock-out half period wrong");
   half_bound_a: assert property (v && co_on |-> hc < half)
      else $error("clock-out edge missing");
endmodule // timer_props

// file: pin_model.sv
// far-side circuitry: direction level and external count source
`timescale 1ns/10ps
module pin_model (
   input  wire sys_clk,
   input  wire pin_out,
   input  wire pin_oe,
   output wire count_in,
   output reg  dir
);
   reg ext;
   assign count_in = pin_oe ? pin_out : ext;
   initial begin
      dir = 1'b1;
      ext = 1'b1;
   end
   task pulse;
      begin
         @(posedge sys_clk);
         ext <= 1'b0;
         repeat (4) @(posedge sys_clk);
         ext <= 1'b1;
         repeat (4) @(posedge sys_clk);
      end
   endtask
   task set_dir(input d);
      begin
         @(posedge sys_clk);
         dir <= d;
      end
   endtask
   task trig;
      begin
         set_dir(1'b0);
         repeat (4) @(posedge sys_clk);
         dir <= 1'b1;
      end
   endtask
endmodule // pin_model

// file: tb_top.sv
// testbench for the up/down reload timer with clock-out
`timescale 1ns/10ps
`include "timer_regs.vh"
module tb_top;
   reg               sys_clk, nrst, wr, rd, po;
   reg [`ADDR_W-1:0] addr;
   reg [7:0]         wdata, v;
   wire [7:0]        rdata;
   wire              cpo, coe, cpi, dir, baud_tick, irq;
   integer           num_errors, tests_run, cyc, i, n, tg, bt;
   updown_reload_timer_clockout uut (.sys_clk(sys_clk), .nrst(nrst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .count_pin_in(cpi),
      .count_pin_out(cpo), .count_pin_oe(coe), .direction_trigger_pin(dir),
      .baud_tick(baud_tick), .irq(irq));
   pin_model pm (.sys_clk(sys_clk), .pin_out(cpo), .pin_oe(coe), .count_in(cpi), .dir(dir));
   always #50 sys_clk = ~sys_clk;
   task wt(input [3:0] a, input [7:0] d);
      begin
         @(posedge sys_clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge sys_clk);
         wr <= 1'b0;
      end
   endtask
   task rdr(input [3:0] a);
      begin
         @(posedge sys_clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge sys_clk);
         rd <= 1'b0;
         @(negedge sys_clk);
         v = rdata;
      end
   endtask
   task chk(input [15:0] g, input [15:0] e);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
         end
      end
   endtask
   task rc(input [3:0] a, input [7:0] e);
      begin
         rdr(a);
         chk(v, e);
      end
   endtask
   task poll;
      begin
         v = 8'h00;
         for (n = 0; n < 200 && v[7] !== 1'b1; n = n + 1) rdr(`OFF_CONTROL);
      end
   endtask
   task cnt;
      begin
         tg = 0;
         bt = 0;
         po = cpo;
         repeat (40) begin
            @(negedge sys_clk);
            if (cpo !== po) tg = tg + 1;
            po = cpo;
            if (baud_tick === 1'b1) bt = bt + 1;
         end
      end
   endtask
   task finish_test;
      begin
         $display("errors %0d checks %0d", num_errors, tests_run);
         if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // whole run needs about 500 cycles
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         num_errors = num_errors + 1;
         finish_test;
      end
   end
   initial begin
      sys_clk = 0; nrst = 0; wr = 0; rd = 0; addr = 0; wdata = 0;
      num_errors = 0; tests_run = 0; cyc = 0;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      for (i = 0; i < 9; i = i + 1) rc(i[3:0], 8'h00);
      wt(`OFF_RELOAD_HI, 8'h12);
      wt(`OFF_COUNT_LO, 8'hfd);
      wt(`OFF_COUNT_HI, 8'hff);
      wt(`OFF_CONTROL, 8'h04);
      poll;
      chk(v, 8'h84);
      rc(`OFF_COUNT_HI, 8'h12);
      rc(`OFF_IRQ_STATUS, 8'h01);
      chk(irq, 1'b0);
      wt(`OFF_IRQ_MASK, 8'h01);
      repeat (2) @(negedge sys_clk);
      chk(irq, 1'b1);
      wt(`OFF_IRQ_STATUS, 8'h01);
      repeat (2) @(negedge sys_clk);
      chk(irq, 1'b0);
      wt(`OFF_CONTROL, 8'h00);
      wt(`OFF_COUNT_LO, 8'h55);
      repeat (50) @(posedge sys_clk);
      rc(`OFF_COUNT_LO, 8'h55);
      wt(`OFF_COUNT_LO, 8'h00);
      wt(`OFF_CONTROL, 8'h06);
      repeat (5) pm.pulse;
      rc(`OFF_COUNT_LO, 8'h05);
      wt(`OFF_CONTROL, 8'h00);
      pm.set_dir(1'b0);
      wt(`OFF_MODE, 8'h01);
      wt(`OFF_RELOAD_HI, 8'h00);
      wt(`OFF_RELOAD_LO, 8'h10);
      wt(`OFF_COUNT_HI, 8'h00);
      wt(`OFF_COUNT_LO, 8'h12);
      wt(`OFF_CONTROL, 8'h04);
      poll;
      chk(v, 8'hc4);
      rc(`OFF_COUNT_HI, 8'hff);
      pm.set_dir(1'b1);
      // stop first: a running count near ffff could overflow between the byte writes
      wt(`OFF_CONTROL, 8'h00);
      wt(`OFF_COUNT_HI, 8'hff);
      wt(`OFF_COUNT_LO, 8'hfe);
      wt(`OFF_IRQ_STATUS, 8'h03);
      wt(`OFF_CONTROL, 8'h04);
      poll;
      chk(v, 8'hc4);
      rc(`OFF_COUNT_HI, 8'h00);
      rc(`OFF_IRQ_STATUS, 8'h01);
      wt(`OFF_MODE, 8'h02);
      wt(`OFF_CONTROL, 8'h00);
      wt(`OFF_RELOAD_HI, 8'hff);
      wt(`OFF_RELOAD_LO, 8'hfe);
      wt(`OFF_COUNT_HI, 8'hff);
      wt(`OFF_COUNT_LO, 8'hfe);
      wt(`OFF_IRQ_STATUS, 8'h03);
      wt(`OFF_CONTROL, 8'h04);
      repeat (8) @(posedge sys_clk);
      cnt;
      chk(tg, 10);
      chk(coe, 1'b1);
      rc(`OFF_IRQ_STATUS, 8'h00);
      rc(`OFF_CONTROL, 8'h04);
      wt(`OFF_CONTROL, 8'h34);
      repeat (8) @(posedge sys_clk);
      cnt;
      chk(bt, 10);
      chk(tg, 10);
      rc(`OFF_CONTROL, 8'h34);
      wt(`OFF_MODE, 8'h00);
      wt(`OFF_CONTROL, 8'h08);
      wt(`OFF_RELOAD_HI, 8'h34);
      wt(`OFF_RELOAD_LO, 8'h56);
      wt(`OFF_COUNT_HI, 8'h00);
      wt(`OFF_COUNT_LO, 8'h00);
      pm.trig;
      repeat (6) @(posedge sys_clk);
      rc(`OFF_COUNT_HI, 8'h34);
      rc(`OFF_COUNT_LO, 8'h56);
      rc(`OFF_CONTROL, 8'h48);
      rc(`OFF_IRQ_STATUS, 8'h02);
      wt(`OFF_CONTROL, 8'h09);
      wt(`OFF_COUNT_LO, 8'h9a);
      pm.trig;
      repeat (6) @(posedge sys_clk);
      rc(`OFF_RELOAD_LO, 8'h9a);
      wt(`OFF_CONTROL, 8'h38);
      wt(`OFF_COUNT_LO, 8'h11);
      pm.trig;
      repeat (6) @(posedge sys_clk);
      rc(`OFF_COUNT_LO, 8'h11);
      rc(`OFF_CONTROL, 8'h38);
      finish_test;
   end
endmodule // tb_top
bind updown_reload_timer_clockout timer_props chk_i (.sys_clk(sys_clk), .nrst(nrst),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .count_pin_in(count_pin_in), .count_pin_out(count_pin_out),
   .count_pin_oe(count_pin_oe), .direction_trigger_pin(direction_trigger_pin),
   .baud_tick(baud_tick), .irq(irq));
